// >>> data_move_instruction_exec_test.sv
// self-checking bench for the data-move executor: apb master, program
// stream driver and data memory model; programs keep clear of guarded cells
// except for one deliberate misuse that checks the guard.
`timescale 1ns/1ps
`default_nettype none
module data_move_instruction_exec_test;
  import dmx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_ready, perr;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  dmx_prog_t prog;
  dmx_dmem_req_t dmem_req;
  logic [7:0] dmem_rdata, acc;
  int wr_count, err_count = 0, checks_done = 0, cyc = 0, last_take = 0;

  dmx_exec dmx_exec_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog(prog), .instr_ready(instr_ready),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));
  dmx_mem dmx_mem_i (.pclk(pclk), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
    .wr_count(wr_count));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  function automatic logic [7:0] mv(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one idle edge after each transfer keeps psel from being driven twice a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    chk("apb wait", 2, n);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  // valid stays up between calls so back-to-back words are offered at once
  task issue(input logic [15:0] w, input int gap);
    int n;
    prog <= '{valid: 1'b1, word: w};
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (instr_ready !== 1'b1 && n < 40);
    if (n >= 40)
      chk("take", 1, 0);
    if (gap > 0)
      chk("issue gap", gap, cyc - last_take);
    last_take = cyc;
  endtask

  task flush;
    prog <= '0;
    repeat (6) @(posedge pclk);
  endtask

  task t_regs;
    rdchk("ctrl", REG_CTRL, 32'h0000_0000);
    rdchk("status", REG_STATUS, 32'h0000_0000);
    rdchk("acc", REG_ACC, 32'h0000_0000);
    rdchk("bank", REG_BANK, 32'h0000_0000);
    rdchk("retired", REG_RETIRED, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("slverr", 1, perr);
    chk("unmapped data", 0, rd);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    rdchk("ctrl run", REG_CTRL, 32'h0000_0001);
    $display("test regs done");
  endtask

  task t_literal;
    logic [7:0] k [3] = '{8'h00, 8'hFF, 8'h5A};
    foreach (k[i])
    begin
      issue({OPC_LIT_ACC, k[i]}, 0);
      flush;
      rdchk("acc literal", REG_ACC, 32'(k[i]));
    end
    issue({OPC_LIT_ACC, 8'h01}, 0);
    issue({OPC_LIT_ACC, 8'h02}, 4);
    flush;
    rdchk("acc second", REG_ACC, 32'h0000_0002);
    rdchk("flags kept", REG_STATUS, 32'h0000_0000);
    $display("test literal done");
  endtask

  task t_file;
    issue({OPC_BANK_LOAD, 8'hA7}, 0);
    issue(16'h5134, 4);
    flush;
    rdchk("bank", REG_BANK, 32'h0000_00A7);
    rdchk("acc file", REG_ACC, 32'(mv(12'h734)));
    rdchk("flags", REG_STATUS, 32'h0000_0000);
    chk("no write", 0, wr_count);
    issue(16'h53FF, 0);
    flush;
    chk("write back", 1, wr_count);
    chk("mem kept", 32'(mv(12'h7FF)), 32'(dmx_mem_i.mem[12'h7FF]));
    rdchk("negative", REG_STATUS, 32'h0000_0001);
    rdchk("acc kept", REG_ACC, 32'(mv(12'h734)));
    issue(16'h5177, 0);
    flush;
    rdchk("zero", REG_STATUS, 32'h0000_0002);
    issue({OPC_LIT_ACC, 8'h80}, 0);
    flush;
    rdchk("flags after literal", REG_STATUS, 32'h0000_0002);
    issue(16'h5090, 0);
    flush;
    rdchk("acc access high", REG_ACC, 32'(mv(12'hF90)));
    issue(16'h5012, 0);
    flush;
    rdchk("acc access low", REG_ACC, 32'(mv(12'h012)));
    acc = mv(12'h012);
    $display("test file done");
  endtask

  task t_copy;
    logic [11:0] src [4] = '{12'h123, 12'h000, DEF_ACC_LOC, 12'h123};
    logic [11:0] dst [4] = '{12'hABC, 12'hFFF, 12'h200, DEF_ACC_LOC};
    logic [7:0] v;
    logic [31:0] r0;
    apb(1'b0, REG_RETIRED, 32'h0000_0000);
    r0 = rd;
    foreach (src[i])
    begin
      v = (src[i] == DEF_ACC_LOC) ? acc : mv(src[i]);
      issue({OPC_MMC_SRC, src[i]}, 0);
      issue({OPC_MMC_DST, dst[i]}, 4);
      flush;
      if (dst[i] == DEF_ACC_LOC)
      begin
        acc = v;
        rdchk("acc copy", REG_ACC, 32'(v));
      end
      else
        chk("mem copy", 32'(v), 32'(dmx_mem_i.mem[dst[i]]));
    end
    apb(1'b0, REG_RETIRED, 32'h0000_0000);
    chk("retired", r0 + 4, rd);
    $display("test copy done");
  endtask

  // deliberate misuse: a copy aimed at the program counter is dropped and flagged
  task t_guard;
    int n;
    n = wr_count;
    issue({OPC_MMC_SRC, 12'h123}, 0);
    issue({OPC_MMC_DST, DEF_PC_LOW_LOC}, 4);
    flush;
    chk("guard no write", n, wr_count);
    chk("guard cell", 32'(mv(DEF_PC_LOW_LOC)), 32'(dmx_mem_i.mem[DEF_PC_LOW_LOC]));
    rdchk("bad dest set", REG_STATUS, 32'h0000_0004);
    apb(1'b1, REG_STATUS, 32'h0000_0004);
    rdchk("bad dest cleared", REG_STATUS, 32'h0000_0000);
    apb(1'b1, REG_ACC, 32'h0000_00FF);
    rdchk("acc read only", REG_ACC, 32'(acc));
    $display("test guard done");
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    prog = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_literal;
    t_file;
    t_copy;
    t_guard;
    test_done;
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge pclk);
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire

// >>> dmx_exec.sv
// data-move instruction executor: file copy, memory-to-memory copy,
// bank load and literal load, four clock phases per instruction cycle.
// assumes program words offered with a valid flag, a data memory that
// returns read data one cycle after the read strobe, and an apb master.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - file copy moves value, updates N and Z
// - dest bit 0 to accumulator, 1 back to file
// - bank-access bit 0 selects the access bank
// - bank-access bit 1 combines bank select and field
// - register field reaches all 256 bank bytes
// - copy uses full 12-bit source and destination
// - copy takes two words and two cycles
// - accumulator may be copy source or destination
// - bank load writes full literal to bank select
// - bank load decoded from upper byte 0000_0001
// - literal load decoded from 0000_1110, flags kept
// - literal load puts literal into accumulator
// - literal load: one word, one cycle, Q4 write
module dmx_exec #(
  parameter logic [11:0] ACC_LOC = dmx_pkg::DEF_ACC_LOC,
  parameter logic [11:0] PC_LOW_LOC = dmx_pkg::DEF_PC_LOW_LOC,
  parameter logic [11:0] STACK_TOP_LOW_LOC = dmx_pkg::DEF_STACK_TOP_LOW_LOC,
  parameter logic [11:0] STACK_TOP_HIGH_LOC = dmx_pkg::DEF_STACK_TOP_HIGH_LOC,
  parameter logic [11:0] STACK_TOP_UPPER_LOC = dmx_pkg::DEF_STACK_TOP_UPPER_LOC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [dmx_pkg::PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire dmx_pkg::dmx_prog_t prog,
  output var logic instr_ready,
  output var dmx_pkg::dmx_dmem_req_t dmem_req,
  input wire logic [dmx_pkg::DATA_W-1:0] dmem_rdata
);
  import dmx_pkg::*;

  dmx_phase_t phase_reg;
  dmx_phase_t phase_next;
  dmx_op_t op_reg;
  dmx_op_t op_dec;
  dmx_dmem_req_t req_next;
  logic [15:0] ir_reg;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic [7:0] bank_select_reg;
  logic [7:0] data_reg;
  logic neg_reg;
  logic zero_reg;
  logic bad_dest_reg;
  logic bad_dest_next;
  logic pend_reg;
  logic src_acc_reg;
  logic run_reg;
  logic [31:0] retired_reg;

  // address of a file-copy operand; shared by the read and the write-back
  function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [7:0] bank);
    logic [7:0] f;
    f = w[7:0];
    if (w[FILE_BANKED_BIT])
      file_addr = {bank[3:0], f};
    else if (f < ACCESS_SPLIT)
      file_addr = {ACCESS_LOW_BANK, f};
    else
      file_addr = {ACCESS_HIGH_BANK, f};
  endfunction

  function automatic logic is_guarded(input logic [11:0] a);
    is_guarded = (a == PC_LOW_LOC) || (a == STACK_TOP_LOW_LOC) ||
      (a == STACK_TOP_HIGH_LOC) || (a == STACK_TOP_UPPER_LOC);
  endfunction

  // instruction decode; a pending copy claims the next word whatever it holds
  wire logic take = (phase_reg == PH_Q1) && instr_ready && prog.valid;
  wire logic dec_file = prog.word[15:10] == OPC_FILE_COPY;
  wire logic dec_mmc = prog.word[15:12] == OPC_MMC_SRC;
  wire logic dec_bank = prog.word[15:8] == OPC_BANK_LOAD;
  wire logic dec_lit = prog.word[15:8] == OPC_LIT_ACC;
  assign op_dec = pend_reg ? OP_MMC_DST :
    dec_file ? OP_FILE :
    dec_mmc ? OP_MMC_SRC :
    dec_bank ? OP_BANK :
    dec_lit ? OP_LIT : OP_NOP;

  // source side, resolved at the take edge so the read strobe lands in Q2
  wire logic [11:0] word_addr = prog.word[11:0];
  wire logic [11:0] src_addr = (op_dec == OP_FILE) ? file_addr(prog.word, bank_select_reg) :
    word_addr;
  wire logic src_is_acc = src_addr == ACC_LOC;
  wire logic src_needed = (op_dec == OP_FILE) || (op_dec == OP_MMC_SRC);
  wire logic [7:0] cap_val = src_acc_reg ? acc_reg : dmem_rdata;
  wire logic [7:0] lit_val = prog.word[7:0];

  // destination side, resolved at the Q3 edge so the write strobe lands in Q4
  wire logic [11:0] dst_addr = (op_reg == OP_FILE) ? file_addr(ir_reg, bank_select_reg) :
    ir_reg[11:0];
  wire logic dst_is_acc = dst_addr == ACC_LOC;
  wire logic dst_bad = (op_reg == OP_MMC_DST) && is_guarded(dst_addr);
  wire logic file_to_acc = !ir_reg[FILE_DEST_BIT] || dst_is_acc;
  wire logic wr_want = ((op_reg == OP_FILE) && ir_reg[FILE_DEST_BIT]) ||
    (op_reg == OP_MMC_DST);
  wire logic wr_go = wr_want && !dst_is_acc && !dst_bad;
  wire logic [7:0] wr_data = (op_reg == OP_FILE) ? cap_val : data_reg;
  wire logic commit = phase_reg == PH_Q4;

  // apb decode; one wait state so that read data comes from a flip-flop
  wire logic apb_wait = psel && penable && !pready;
  wire logic apb_done = psel && penable && pready;
  wire logic hit_ctrl = paddr == REG_CTRL;
  wire logic hit_status = paddr == REG_STATUS;
  wire logic hit_any = hit_ctrl || hit_status || (paddr == REG_ACC) ||
    (paddr == REG_BANK) || (paddr == REG_RETIRED);
  wire logic [31:0] status_word = {28'h000_0000, pend_reg, bad_dest_reg, zero_reg, neg_reg};
  wire logic [31:0] rd_mux = hit_ctrl ? {31'h0000_0000, run_reg} :
    hit_status ? status_word :
    (paddr == REG_ACC) ? {24'h00_0000, acc_reg} :
    (paddr == REG_BANK) ? {24'h00_0000, bank_select_reg} :
    (paddr == REG_RETIRED) ? retired_reg : 32'h0000_0000;
  wire logic status_clr = apb_done && pwrite && hit_status && pwdata[ST_BAD_DEST_BIT];

  // a forbidden copy target is skipped and flagged; a new flag beats a clear
  assign bad_dest_next = (phase_reg == PH_Q3 && dst_bad) || (bad_dest_reg && !status_clr);

  always_comb
  begin
    case (phase_reg)
      PH_Q1: phase_next = take ? PH_Q2 : PH_Q1;
      PH_Q2: phase_next = PH_Q3;
      PH_Q3: phase_next = PH_Q4;
      PH_Q4: phase_next = PH_Q1;
      default: phase_next = PH_Q1;
    endcase
  end

  always_comb
  begin
    req_next = dmem_req;
    req_next.rd = 1'b0;
    req_next.wr = 1'b0;
    if (take && src_needed && !src_is_acc)
    begin
      req_next.rd = 1'b1;
      req_next.addr = src_addr;
    end
    if (phase_reg == PH_Q3 && wr_go)
    begin
      req_next.wr = 1'b1;
      req_next.addr = dst_addr;
      req_next.wdata = wr_data;
    end
  end

  always_comb
  begin
    acc_next = acc_reg;
    if (commit)
    begin
      case (op_reg)
        OP_FILE: acc_next = file_to_acc ? data_reg : acc_reg;
        OP_MMC_DST: acc_next = dst_is_acc ? data_reg : acc_reg;
        OP_LIT: acc_next = ir_reg[7:0];
        default: acc_next = acc_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= PH_Q1;
      op_reg <= OP_NOP;
      instr_ready <= 1'b0;
      dmem_req <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      op_reg <= take ? op_dec : op_reg;
      instr_ready <= (phase_next == PH_Q1) && run_reg;
      dmem_req <= req_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_reg <= 16'h0000;
      src_acc_reg <= 1'b0;
      pend_reg <= 1'b0;
      data_reg <= 8'h00;
    end
    else
    begin
      ir_reg <= take ? prog.word : ir_reg;
      src_acc_reg <= take ? src_is_acc : src_acc_reg;
      pend_reg <= take ? (op_dec == OP_MMC_SRC) : pend_reg;
      if (phase_reg == PH_Q3 && (op_reg == OP_FILE || op_reg == OP_MMC_SRC))
        data_reg <= cap_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg <= ACC_RST;
      bank_select_reg <= BANK_RST;
      neg_reg <= 1'b0;
      zero_reg <= 1'b0;
      retired_reg <= RETIRED_RST;
    end
    else
    begin
      acc_reg <= acc_next;
      if (commit && op_reg == OP_BANK)
        bank_select_reg <= ir_reg[7:0];
      if (commit && op_reg == OP_FILE)
      begin
        neg_reg <= data_reg[NEG_BIT_OF_DATA];
        zero_reg <= data_reg == 8'h00;
      end
      if (commit && op_reg != OP_MMC_SRC)
        retired_reg <= retired_reg + 32'h0000_0001;
    end
  end

  // software halts fetch through the run bit; the cycle in flight still ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_reg <= RUN_RST;
      bad_dest_reg <= 1'b0;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      if (apb_done && pwrite && hit_ctrl)
        run_reg <= pwdata[CTRL_RUN_BIT];
      bad_dest_reg <= bad_dest_next;
      pready <= apb_wait;
      prdata <= apb_wait && !pwrite ? rd_mux : 32'h0000_0000;
      pslverr <= apb_wait && !hit_any;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !run_reg);

  sequence s_lit_take;
    take && op_dec == OP_LIT;
  endsequence

  sequence s_mmc_first;
    take && op_dec == OP_MMC_SRC;
  endsequence

  sequence s_mmc_second;
    take && op_dec == OP_MMC_DST;
  endsequence

  a_lit_acc_load: assert property (s_lit_take |-> ##4 acc_reg == $past(lit_val, 4))
    else $error("literal not in accumulator after one cycle");

  a_lit_flags_kept: assert property (s_lit_take |-> ##4
    (neg_reg == $past(neg_reg, 4)) && (zero_reg == $past(zero_reg, 4)))
    else $error("literal load changed a flag");

  a_cycle_length: assert property (take |=> !instr_ready [*3] ##1 instr_ready)
    else $error("instruction cycle is not four phases");

  a_bank_load_value: assert property (take && op_dec == OP_BANK |->
    ##4 bank_select_reg == $past(lit_val, 4))
    else $error("bank select not loaded with literal");

  a_file_flags: assert property (commit && op_reg == OP_FILE |=>
    zero_reg == ($past(data_reg) == 8'h00) && neg_reg == $past(data_reg[7]))
    else $error("file copy flags wrong");

  a_file_to_acc: assert property (commit && op_reg == OP_FILE && !ir_reg[FILE_DEST_BIT] |=>
    acc_reg == $past(data_reg))
    else $error("file copy did not reach accumulator");

  a_access_bank_addr: assert property (take && op_dec == OP_FILE && !src_is_acc |=>
    dmem_req.rd && dmem_req.addr[7:0] == $past(lit_val) &&
    (($past(prog.word[FILE_BANKED_BIT]) && dmem_req.addr[11:8] == bank_select_reg[3:0]) ||
    (!$past(prog.word[FILE_BANKED_BIT]) && (dmem_req.addr[11:8] ==
    (dmem_req.addr[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK)))))
    else $error("file copy read address wrong");

  a_mmc_two_cycles: assert property (s_mmc_first |-> ##4 pend_reg && phase_reg == PH_Q1)
    else $error("memory copy second word not awaited");

  a_mmc_dest_write: assert property (s_mmc_second |-> ##3
    (dmem_req.wr == ($past(word_addr, 3) != ACC_LOC && !is_guarded($past(word_addr, 3)))) &&
    (!dmem_req.wr || (dmem_req.addr == $past(word_addr, 3) && dmem_req.wdata == data_reg)))
    else $error("memory copy write wrong");

  a_guarded_dest: assert property (s_mmc_second ##0 is_guarded(word_addr) |-> ##3
    bad_dest_reg && !dmem_req.wr)
    else $error("guarded destination written");

  a_bad_dest_sticky: assert property (bad_dest_reg && !status_clr |=> bad_dest_reg)
    else $error("bad destination flag lost without a clear");

  a_copy_no_dummy: assert property (s_mmc_second |=> !dmem_req.rd)
    else $error("memory copy second word read memory");

  a_acc_src_direct: assert property (take && src_needed && src_is_acc |=>
    !dmem_req.rd)
    else $error("accumulator source read from memory");

  sequence s_file_back;
    take && op_dec == OP_FILE && prog.word[FILE_DEST_BIT] && !src_is_acc;
  endsequence

  a_file_write_back: assert property (s_file_back |-> ##3
    dmem_req.wr && dmem_req.addr == $past(src_addr, 3) && dmem_req.wdata == data_reg)
    else $error("file copy write-back wrong");

  // one wait state, error flag with the answer, ready never stretched
  a_apb_wait_state: assert property (apb_wait |=> pready && (pslverr == !$past(hit_any)))
    else $error("apb answer not after one wait state");

  a_apb_single_pulse: assert property (pready |=> !pready)
    else $error("apb ready held for two cycles");

endmodule

`default_nettype wire

// >>> dmx_mem.sv
// data memory model on the far side of the executor's byte bus.
// assumes registered one-cycle read and write strobes from the executor.
`timescale 1ns/1ps
`default_nettype none
module dmx_mem
  import dmx_pkg::*;
(
  input wire logic pclk,
  input wire dmx_pkg::dmx_dmem_req_t dmem_req,
  output var logic [7:0] dmem_rdata,
  output var int wr_count
);
  logic [7:0] mem [0:4095];
  initial
  begin
    wr_count = 0;
    dmem_rdata = 8'h00;
    for (int a = 0; a < 4096; a++)
      mem[a] = 8'(a) ^ {2{4'(a >> 8)}};
  end
  // data is good only in the cycle after a read; it keeps changing otherwise
  always @(posedge pclk)
  begin
    if (dmem_req.rd)
      dmem_rdata <= mem[dmem_req.addr];
    else
      dmem_rdata <= ~dmem_rdata;
    if (dmem_req.wr)
    begin
      mem[dmem_req.addr] <= dmem_req.wdata;
      wr_count <= wr_count + 1;
    end
  end
endmodule
`default_nettype wire

// >>> dmx_pkg.sv
// package for the data-move instruction executor: opcodes, register map,
// field positions, reset values, phase and operation types, carrier structs.
// assumes a 32-bit apb register bus and a 12-bit byte-addressed data space.
`default_nettype none

package dmx_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned DADDR_W = 12;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned PADDR_W = 8;

  // opcode patterns
  localparam logic [5:0] OPC_FILE_COPY = 6'h14;
  localparam logic [3:0] OPC_MMC_SRC = 4'hC;
  localparam logic [3:0] OPC_MMC_DST = 4'hF;
  localparam logic [7:0] OPC_BANK_LOAD = 8'h01;
  localparam logic [7:0] OPC_LIT_ACC = 8'h0E;

  // field positions inside the file-copy word and the data byte
  localparam int unsigned FILE_DEST_BIT = 9;
  localparam int unsigned FILE_BANKED_BIT = 8;
  localparam int unsigned NEG_BIT_OF_DATA = 7;

  // access bank: low half of bank 0 and high half of the top bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // data-space locations of core registers (plain defaults)
  localparam logic [11:0] DEF_ACC_LOC = 12'hFF0;
  localparam logic [11:0] DEF_PC_LOW_LOC = 12'hFF1;
  localparam logic [11:0] DEF_STACK_TOP_LOW_LOC = 12'hFF2;
  localparam logic [11:0] DEF_STACK_TOP_HIGH_LOC = 12'hFF3;
  localparam logic [11:0] DEF_STACK_TOP_UPPER_LOC = 12'hFF4;

  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0C;
  localparam logic [7:0] REG_RETIRED = 8'h10;

  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned ST_NEG_BIT = 0;
  localparam int unsigned ST_ZERO_BIT = 1;
  localparam int unsigned ST_BAD_DEST_BIT = 2;
  localparam int unsigned ST_PEND_BIT = 3;

  // reset values
  localparam logic RUN_RST = 1'b0;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [31:0] RETIRED_RST = 32'h0000_0000;

  typedef enum {PH_Q1, PH_Q2, PH_Q3, PH_Q4} dmx_phase_t;
  typedef enum {OP_NOP, OP_FILE, OP_MMC_SRC, OP_MMC_DST, OP_BANK, OP_LIT} dmx_op_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } dmx_prog_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dmx_dmem_req_t;

endpackage

`default_nettype wire
